//--- rtl/dbas_pkg.sv
// Package for the drive, brake and auxiliary output sequencer.
// Assumes one 125 MHz system clock and an AXI4-Lite register slave.
package dbas_pkg;
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          TICK_NS       = 10_000_000;
	localparam int          TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int          TICKS_PER_S   = 100;
	localparam int          TICKS_PER_QS  = 25;
	localparam int          TMR_W         = 13;
	localparam int          DIV_W         = 24;
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_GAIN   = 8'h04;
	localparam logic [7:0]  OFS_BRAKE  = 8'h08;
	localparam logic [7:0]  OFS_TRAP   = 8'h0c;
	localparam logic [7:0]  OFS_MOTION = 8'h10;
	localparam logic [7:0]  OFS_FENCE  = 8'h14;
	localparam logic [7:0]  OFS_AUXDLY = 8'h18;
	localparam logic [7:0]  OFS_STATUS = 8'h1c;
	localparam logic [7:0]  OFS_MASK   = 8'h20;
	// Field positions
	localparam int          CTRL_V36_BIT  = 0;
	localparam int          CTRL_MODE_LSB = 4;
	localparam int          CTRL_POL_BIT  = 8;
	localparam int          BRK_TIME_LSB  = 16;
	localparam int          TRAP_TIME_LSB = 8;
	localparam int          FENCE_MAX_LSB = 8;
	localparam int          FENCE_LOCK_BIT = 16;
	// Limits and steps
	localparam logic [10:0] GAIN_MAX    = 11'h4fb;
	localparam logic [10:0] GAIN_STEP   = 11'h005;
	localparam logic [6:0]  DLY_MAX     = 7'h64;
	localparam logic [6:0]  PCT_MAX     = 7'h64;
	localparam logic [2:0]  TRAP_T_MAX  = 3'h5;
	localparam logic [7:0]  AUXDLY_MAX  = 8'hf0;
	// Reset values
	localparam logic [6:0]  DLY_RST     = 7'h1e;
	localparam logic [6:0]  BTIME_RST   = 7'h64;
	localparam logic [7:0]  FMIN_RST    = 8'h00;
	localparam logic [7:0]  FMAX_RST    = 8'h64;
	localparam logic [10:0] GAIN_RST    = 11'h096;
	// Status bits
	localparam int          ST_REL  = 0;
	localparam int          ST_TON  = 1;
	localparam int          ST_TEXP = 2;
	localparam int          ST_AOFF = 3;
	localparam int          ST_OPEN = 4;
	localparam int          ST_W    = 5;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		AUX_OFF   = 3'h0,
		AUX_BRAKE = 3'h1,
		AUX_FWD   = 3'h2,
		AUX_REV   = 3'h3,
		AUX_TRAC  = 3'h4
	} dbas_aux_mode_t;

	typedef enum logic [3:0] {
		BS_IDLE = 4'h1,
		BS_PULL = 4'h2,
		BS_RUN  = 4'h4,
		BS_HOLD = 4'h8
	} dbas_brk_state_t;
endpackage

//--- rtl/dbas_tmr_if.sv
// Control bundle between the sequencer and one tick timer.
// Assumes both ends share the system clock.
`timescale 1ns/1ns
interface dbas_tmr_if;
	import dbas_pkg::*;
	logic             clr;
	logic             run;
	logic [TMR_W-1:0] limit;
	logic             done;
	modport ctl (output clr, output run, output limit, input done);
	modport tmr (input clr, input run, input limit, output done);
endinterface

//--- rtl/dbas_timer.sv
// Elapsed-time counter in 10 ms ticks, flags when the limit is reached.
// Assumes tick_in is a one-cycle enable on the system clock.
`timescale 1ns/1ns
module dbas_timer (
	input  wire logic clk_sys_in,
	input  wire logic resetn_in,
	input  wire logic tick_in,
	dbas_tmr_if.tmr   tmr_if
);
	import dbas_pkg::*;
	logic [TMR_W-1:0] cnt_q;
	logic             done_q;

	assign tmr_if.done = done_q;

	// Done lags by a cycle, so a zero limit still costs one clock
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (tmr_if.clr) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			if (tmr_if.run && tick_in && !done_q)
				cnt_q <= cnt_q + 1'b1;
			done_q <= tmr_if.run && (cnt_q >= tmr_if.limit);
		end
	end
endmodule // dbas_timer

//--- rtl/dbas_seq.sv
// Assumes pins are asynchronous and are synchronised here.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module dbas_seq
	import dbas_pkg::*;
#(
	parameter int          TICK_CYC   = TICK_CYCLES,
	parameter bit          VOLT_PROG  = 1'b1
) (
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	input  wire logic        drive_req_in,
	input  wire logic        dir_fwd_in,
	input  wire logic        dir_rev_in,
	input  wire logic        trap_sw_in,
	input  wire logic        inhibit_in,
	input  wire logic        brake_open_in,
	output logic             motor_en_out,
	output logic             aux1_out,
	output logic             brake_chk_en_out,
	output logic [6:0]       speed_cmd_out,
	output logic             trap_ovr_out,
	output logic [10:0]      stop_gain_out,
	output logic [31:0]      motion_out,
	output logic             supply_36v_out,
	output logic             irq_out
);
	import dbas_pkg::*;

	initial begin
		if (TICK_CYC < 1 || TICK_CYC >= 2**DIV_W)
			$error("TICK_CYC out of range");
	end

	// Merge written byte lanes into the old word
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				o[8*i +: 8] = n[8*i +: 8];
		return o;
	endfunction

	function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// nearest multiple of the step
	// One spare bit so a near-full write cannot wrap to zero
	function automatic logic [10:0] round_gain(input logic [15:0] v);
		logic [16:0] r;
		r = (17'(v) + 17'h00002) / 17'(GAIN_STEP) * 17'(GAIN_STEP);
		return (r >= 17'(GAIN_MAX)) ? GAIN_MAX : r[10:0];
	endfunction

	logic [3:0] sync1_q, sync2_q;
	logic [1:0] sync_open_q;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_q     <= '0;
			sync2_q     <= '0;
			sync_open_q <= '0;
		end else begin
			sync1_q     <= {inhibit_in, trap_sw_in, dir_rev_in, dir_fwd_in};
			sync2_q     <= sync1_q;
			sync_open_q <= {sync_open_q[0], brake_open_in};
		end
	end
	wire fwd_s   = sync2_q[0];
	wire rev_s   = sync2_q[1];
	wire trap_s  = sync2_q[2];
	wire inh_s   = sync2_q[3];
	logic drv_m_q, drv_q;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			drv_m_q <= 1'b0;
			drv_q   <= 1'b0;
		end else begin
			drv_m_q <= drive_req_in;
			drv_q   <= drv_m_q;
		end
	end

	// Tick divider; the 10 ms rate is an enable, not a clock
	logic [DIV_W-1:0] div_q;
	logic             tick_q;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == DIV_W'(TICK_CYC - 1));
			div_q  <= (div_q == DIV_W'(TICK_CYC - 1)) ? '0 : div_q + 1'b1;
		end
	end

	// Register file
	logic [10:0]    gain_q;
	logic [6:0]     dly_q, btime_q, tspd_q;
	logic [2:0]     ttime_q;
	logic [31:0]    motion_q;
	logic [7:0]     fmin_q, fmax_q, auxdly_q;
	logic           flock_q, v36_q, pol_q;
	dbas_aux_mode_t mode_q;
	logic [ST_W-1:0] sts_q, mask_q, ev;

	logic aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q, rresp_q;

	wire aw_hs = s_axi_awvalid_in && aw_rdy_q;
	wire w_hs  = s_axi_wvalid_in && w_rdy_q;
	wire wr_go = !aw_rdy_q && !w_rdy_q && !bvalid_q;
	wire b_hs  = bvalid_q && s_axi_bready_in;
	wire ar_hs = s_axi_arvalid_in && ar_rdy_q;
	wire r_hs  = rvalid_q && s_axi_rready_in;

	wire [31:0] ctrl_rd = {23'h0, pol_q, 1'b0, mode_q, 3'h0, v36_q};
	wire [31:0] brk_rd  = {9'h0, btime_q, 9'h0, dly_q};
	wire [31:0] trap_rd = {21'h0, ttime_q, 1'b0, tspd_q};
	wire [31:0] fnc_rd  = {15'h0, flock_q, fmax_q, fmin_q};
	wire [31:0] ctrl_w = merge(ctrl_rd, wdata_q, wstrb_q);
	wire [31:0] brk_w  = merge(brk_rd, wdata_q, wstrb_q);
	wire [31:0] trap_w = merge(trap_rd, wdata_q, wstrb_q);
	wire [31:0] fnc_w  = merge(fnc_rd, wdata_q, wstrb_q);
	wire [31:0] gain_w = merge({21'h0, gain_q}, wdata_q, wstrb_q);
	wire [31:0] mot_w  = merge(motion_q, wdata_q, wstrb_q);
	wire [31:0] aux_w  = merge({24'h0, auxdly_q}, wdata_q, wstrb_q);
	wire [31:0] msk_w  = merge({27'h0, mask_q}, wdata_q, wstrb_q);
	wire [2:0]  mode_w = ctrl_w[CTRL_MODE_LSB +: 3];
	wire wr_known = awaddr_q inside {OFS_CTRL, OFS_GAIN, OFS_BRAKE, OFS_TRAP, OFS_MOTION,
		OFS_FENCE, OFS_AUXDLY, OFS_STATUS, OFS_MASK};

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			gain_q   <= GAIN_RST;
			dly_q    <= DLY_RST;
			btime_q  <= BTIME_RST;
			tspd_q   <= '0;
			ttime_q  <= '0;
			motion_q <= '0;
			fmin_q   <= FMIN_RST;
			fmax_q   <= FMAX_RST;
			flock_q  <= 1'b0;
			auxdly_q <= '0;
			v36_q    <= 1'b0;
			pol_q    <= 1'b0;
			mode_q   <= AUX_OFF;
			mask_q   <= '0;
		end else if (wr_go) begin
			unique case (awaddr_q)
				OFS_CTRL: begin
					// one bit picks 24 V or 36 V, writable only when VOLT_PROG is set
					if (VOLT_PROG)
						v36_q <= ctrl_w[CTRL_V36_BIT];
					pol_q <= ctrl_w[CTRL_POL_BIT];
					// illegal mode codes fall back to off
					mode_q <= (mode_w > AUX_TRAC) ? AUX_OFF : dbas_aux_mode_t'(mode_w);
				end
				OFS_GAIN:   gain_q <= round_gain(gain_w[15:0]);
				OFS_BRAKE: begin
					// delay and brake time clamped to 1 s
					dly_q   <= (brk_w[6:0] > DLY_MAX) ? DLY_MAX : brk_w[6:0];
					btime_q <= (brk_w[BRK_TIME_LSB +: 7] > DLY_MAX) ? DLY_MAX
						: brk_w[BRK_TIME_LSB +: 7];
				end
				OFS_TRAP: begin
					tspd_q  <= (trap_w[6:0] > PCT_MAX) ? PCT_MAX : trap_w[6:0];
					ttime_q <= (trap_w[TRAP_TIME_LSB +: 3] > TRAP_T_MAX) ? TRAP_T_MAX
						: trap_w[TRAP_TIME_LSB +: 3];
				end
				OFS_MOTION: motion_q <= mot_w;
				OFS_FENCE: begin
					// Factory fences freeze once the lock bit is set
					if (!flock_q) begin
						fmin_q  <= fnc_w[7:0];
						fmax_q  <= fnc_w[FENCE_MAX_LSB +: 8];
						flock_q <= fnc_w[FENCE_LOCK_BIT];
					end
				end
				// at most 60 s in quarter seconds
				OFS_AUXDLY: auxdly_q <= (aux_w[7:0] > AUXDLY_MAX) ? AUXDLY_MAX : aux_w[7:0];
				OFS_MASK:   mask_q <= msk_w[ST_W-1:0];
				default: ;
			endcase
		end
	end

	// every motion byte held inside the fences
	wire [31:0] motion_cl = {clamp(motion_q[31:24], fmin_q, fmax_q),
		clamp(motion_q[23:16], fmin_q, fmax_q), clamp(motion_q[15:8], fmin_q, fmax_q),
		clamp(motion_q[7:0], fmin_q, fmax_q)};

	wire [31:0] rd_mux =
		(s_axi_araddr_in == OFS_CTRL)   ? ctrl_rd :
		(s_axi_araddr_in == OFS_GAIN)   ? {21'h0, gain_q} :
		(s_axi_araddr_in == OFS_BRAKE)  ? brk_rd :
		(s_axi_araddr_in == OFS_TRAP)   ? trap_rd :
		(s_axi_araddr_in == OFS_MOTION) ? motion_cl :
		(s_axi_araddr_in == OFS_FENCE)  ? fnc_rd :
		(s_axi_araddr_in == OFS_AUXDLY) ? {24'h0, auxdly_q} :
		(s_axi_araddr_in == OFS_STATUS) ? {27'h0, sts_q} :
		(s_axi_araddr_in == OFS_MASK)   ? {27'h0, mask_q} : 32'h0;
	wire rd_known = (s_axi_araddr_in <= OFS_MASK) && (s_axi_araddr_in[1:0] == 2'h0);

	// Bus handshake; one write and one read in flight
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			aw_rdy_q <= 1'b1;
			w_rdy_q  <= 1'b1;
			ar_rdy_q <= 1'b1;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
			bresp_q  <= RESP_OKAY;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= '0;
		end else begin
			if (aw_hs) begin
				awaddr_q <= s_axi_awaddr_in;
				aw_rdy_q <= 1'b0;
			end
			if (w_hs) begin
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
				w_rdy_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_hs) begin
				bvalid_q <= 1'b0;
				aw_rdy_q <= 1'b1;
				w_rdy_q  <= 1'b1;
			end
			if (ar_hs) begin
				rdata_q  <= rd_mux;
				rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
				rvalid_q <= 1'b1;
				ar_rdy_q <= 1'b0;
			end
			if (r_hs) begin
				rvalid_q <= 1'b0;
				ar_rdy_q <= 1'b1;
			end
		end
	end

	// Timers
	dbas_tmr_if brk_t ();
	dbas_tmr_if trap_t ();
	dbas_tmr_if aux_t ();
	dbas_timer u_brk_tmr (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.tick_in(tick_q), .tmr_if(brk_t));
	dbas_timer u_trap_tmr (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.tick_in(tick_q), .tmr_if(trap_t));
	dbas_timer u_aux_tmr (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.tick_in(tick_q), .tmr_if(aux_t));

	// Brake sequencer
	dbas_brk_state_t bs_q, bs_d;
	always_comb begin
		bs_d = bs_q;
		unique case (bs_q)
			BS_IDLE: if (drv_q) bs_d = BS_PULL;
			BS_PULL: bs_d = !drv_q ? BS_HOLD : (brk_t.done ? BS_RUN : BS_PULL);
			BS_RUN:  if (!drv_q) bs_d = BS_HOLD;
			BS_HOLD: bs_d = drv_q ? BS_RUN : (brk_t.done ? BS_IDLE : BS_HOLD);
			default: bs_d = BS_IDLE;
		endcase
	end
	// motor on at pull start, release after the delay, or at once if drive drops during pull
	assign brk_t.clr   = (bs_d != bs_q);
	assign brk_t.run   = (bs_q == BS_PULL) || (bs_q == BS_HOLD);
	assign brk_t.limit = TMR_W'(bs_q == BS_PULL ? dly_q : btime_q);
	wire brk_rel_d = (bs_d == BS_RUN) || (bs_d == BS_HOLD);

	// polarity folds the switch into an active level
	wire trap_act = trap_s ^ pol_q;
	assign trap_t.clr   = !trap_act;
	assign trap_t.run   = trap_act;
	assign trap_t.limit = TMR_W'(ttime_q) * TMR_W'(TICKS_PER_S);
	// override ends at the timeout even if held
	wire ovr_d = trap_act && !trap_t.done && (ttime_q != 3'h0);

	wire trac = (mode_q == AUX_FWD) || (mode_q == AUX_REV) || (mode_q == AUX_TRAC);
	wire cond = (mode_q == AUX_FWD && fwd_s) || (mode_q == AUX_REV && rev_s)
		|| (mode_q == AUX_TRAC && (fwd_s || rev_s));
	logic inh_hold_q, aux_q;
	// inhibit latches in every traction mode; it outranks re-entry
	wire inh_hold_d = !trac ? 1'b0 : (inh_s && aux_q) ? 1'b1
		: (!inh_s && !aux_q) ? 1'b0 : inh_hold_q;
	wire keep = cond && !inh_s && !inh_hold_q;
	assign aux_t.clr   = keep || !trac;
	// count the off-delay once the condition drops
	assign aux_t.run   = aux_q && !keep;
	assign aux_t.limit = TMR_W'(auxdly_q) * TMR_W'(TICKS_PER_QS);
	// off idles, brake follows the release; brake ignores delay
	wire aux_d = (mode_q == AUX_BRAKE) ? brk_rel_d
		: trac ? (keep || (aux_q && !aux_t.done)) : 1'b0;
	// open-circuit check only in brake mode
	wire chk_d = (mode_q == AUX_BRAKE);

	logic rel_q, ovr_q, open_q;
	assign ev[ST_REL]  = brk_rel_d && !rel_q;
	assign ev[ST_TON]  = ovr_d && !ovr_q;
	assign ev[ST_TEXP] = ovr_q && !ovr_d && trap_act;
	assign ev[ST_AOFF] = aux_q && !aux_d;
	assign ev[ST_OPEN] = chk_d && sync_open_q[1] && !open_q;
	wire rd_sts = ar_hs && (s_axi_araddr_in == OFS_STATUS);
	// Set wins over the read clear
	wire [ST_W-1:0] sts_d = (rd_sts ? '0 : sts_q) | ev;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bs_q       <= BS_IDLE;
			inh_hold_q <= 1'b0;
			aux_q      <= 1'b0;
			rel_q      <= 1'b0;
			ovr_q      <= 1'b0;
			open_q     <= 1'b0;
			sts_q      <= '0;
			motor_en_out     <= 1'b0;
			brake_chk_en_out <= 1'b0;
			speed_cmd_out    <= '0;
			motion_out       <= '0;
			irq_out          <= 1'b0;
		end else begin
			bs_q       <= bs_d;
			inh_hold_q <= inh_hold_d;
			aux_q      <= aux_d;
			rel_q      <= brk_rel_d;
			ovr_q      <= ovr_d;
			open_q     <= chk_d && sync_open_q[1];
			sts_q      <= sts_d;
			motor_en_out     <= (bs_d != BS_IDLE);
			brake_chk_en_out <= chk_d;
			// override speed replaces the forward speed
			speed_cmd_out    <= ovr_d ? tspd_q : motion_cl[22:16];
			motion_out       <= motion_cl;
			irq_out          <= |(sts_d & mask_q);
		end
	end

	assign aux1_out          = aux_q;
	assign trap_ovr_out      = ovr_q;
	assign stop_gain_out     = gain_q;
	assign supply_36v_out    = v36_q;
	assign s_axi_awready_out = aw_rdy_q;
	assign s_axi_wready_out  = w_rdy_q;
	assign s_axi_bvalid_out  = bvalid_q;
	assign s_axi_bresp_out   = bresp_q;
	assign s_axi_arready_out = ar_rdy_q;
	assign s_axi_rvalid_out  = rvalid_q;
	assign s_axi_rdata_out   = rdata_q;
	assign s_axi_rresp_out   = rresp_q;

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	AST_GAIN_GRID: assert property (gain_q % GAIN_STEP == 0 && gain_q <= GAIN_MAX)
		else $error("gain off grid");
	AST_DLY_MAX: assert property (dly_q <= DLY_MAX)
		else $error("release delay above 1 s");
	AST_MOTOR_FIRST: assert property ($rose(aux1_out) && mode_q == AUX_BRAKE
		|-> $past(motor_en_out)) else $error("brake released before motor");
	AST_TRAP_IDLE: assert property (!trap_act |=> !trap_ovr_out)
		else $error("override without active switch");
	AST_TRAP_SPEED: assert property (ovr_d |=> speed_cmd_out == $past(tspd_q))
		else $error("override speed wrong");
	AST_FENCE: assert property (fmin_q <= fmax_q |=> motion_out[7:0] >= $past(fmin_q)
		&& motion_out[7:0] <= $past(fmax_q)) else $error("accel outside fences");
	AST_AUX_OFF: assert property (mode_q == AUX_OFF && $past(mode_q) == AUX_OFF
		|-> !aux1_out) else $error("aux active in off mode");
	AST_CHK_OFF: assert property (mode_q != AUX_BRAKE |=> !brake_chk_en_out)
		else $error("open check outside brake mode");
	AST_REENTRY: assert property (trac && keep |=> aux1_out)
		else $error("aux dropped while condition holds");
	COV_RELEASE: cover property (bs_q == BS_PULL ##1 bs_q == BS_RUN);
	COV_TRAP_TO: cover property (ovr_q ##1 !ovr_q && trap_act);
	COV_AUX_OFF: cover property (trac && aux_q ##1 !aux_q);
	COV_IRQ: cover property ($rose(irq_out));
endmodule // dbas_seq

//--- dv/dbas_far_model.sv
// Far side stand-in: vehicle motion, brake coil sense.
// Assumes the bench steers it through its want inputs.
`timescale 1ns/1ns
module dbas_far_model (
	input  wire logic motor_en_in,
	input  wire logic want_drive_in,
	input  wire logic want_rev_in,
	input  wire logic coil_cut_in,
	output logic      drive_req_out,
	output logic      dir_fwd_out,
	output logic      dir_rev_out,
	output logic      brake_open_out
);
	// Wheels turn only once the stage is enabled
	assign drive_req_out  = want_drive_in;
	assign dir_fwd_out    = want_drive_in & ~want_rev_in & motor_en_in;
	assign dir_rev_out    = want_drive_in & want_rev_in & motor_en_in;
	assign brake_open_out = coil_cut_in;
endmodule // dbas_far_model

//--- dv/drive_brake_aux_sequencer_bench.sv
// Self-checking bench for the drive, brake and aux output sequencer.
// Assumes a 10 cycle tick so timed sequences stay short.
`timescale 1ns/1ns
module drive_brake_aux_sequencer_bench;
	import dbas_pkg::*;
	localparam int TK = 10;
	typedef struct packed {
		logic [7:0]  a;
		logic        we;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  r;
	} dbas_row_t;
	localparam dbas_row_t ROWS [15] = '{
		'{OFS_CTRL, 1'b0, 32'h0, 32'h0, RESP_OKAY},
		'{OFS_GAIN, 1'b0, 32'h0, 32'h96, RESP_OKAY},
		'{OFS_BRAKE, 1'b0, 32'h0, 32'h0064001e, RESP_OKAY},
		'{OFS_FENCE, 1'b0, 32'h0, 32'h6400, RESP_OKAY},
		'{OFS_GAIN, 1'b1, 32'h8, 32'ha, RESP_OKAY},
		'{OFS_GAIN, 1'b1, 32'h7ff, 32'h4fb, RESP_OKAY},
		'{OFS_BRAKE, 1'b1, 32'h00700065, 32'h00640064, RESP_OKAY},
		'{OFS_TRAP, 1'b1, 32'h765, 32'h564, RESP_OKAY},
		'{OFS_AUXDLY, 1'b1, 32'hff, 32'hf0, RESP_OKAY},
		'{OFS_MOTION, 1'b1, 32'h65326400, 32'h64326400, RESP_OKAY},
		'{OFS_FENCE, 1'b1, 32'h1320a, 32'h1320a, RESP_OKAY},
		'{OFS_FENCE, 1'b1, 32'h6400, 32'h1320a, RESP_OKAY},
		'{OFS_MOTION, 1'b0, 32'h0, 32'h3232320a, RESP_OKAY},
		'{8'h40, 1'b1, 32'h1, 32'h0, RESP_SLVERR},
		'{OFS_CTRL, 1'b1, 32'h101, 32'h101, RESP_OKAY}};
	logic        clk_sys_in, resetn_in, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, motion;
	logic [1:0]  bresp, rresp, resp;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid, want_drive, want_rev;
	logic        coil_cut, trap_sw, inhibit, drive_req, dir_fwd, dir_rev, brake_open;
	logic        motor_en, aux1, chk_en, ovr, v36, irq;
	logic [6:0]  speed;
	logic [10:0] gain;
	int          n_errors, n_tests, c;

	dbas_seq #(.TICK_CYC(TK), .VOLT_PROG(1'b1)) dbas_seq_i (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .drive_req_in(drive_req), .dir_fwd_in(dir_fwd),
		.dir_rev_in(dir_rev), .trap_sw_in(trap_sw), .inhibit_in(inhibit),
		.brake_open_in(brake_open), .motor_en_out(motor_en), .aux1_out(aux1),
		.brake_chk_en_out(chk_en), .speed_cmd_out(speed), .trap_ovr_out(ovr),
		.stop_gain_out(gain), .motion_out(motion), .supply_36v_out(v36), .irq_out(irq));
	dbas_far_model dbas_far_model_i (.motor_en_in(motor_en), .want_drive_in(want_drive),
		.want_rev_in(want_rev), .coil_cut_in(coil_cut), .drive_req_out(drive_req),
		.dir_fwd_out(dir_fwd), .dir_rev_out(dir_rev), .brake_open_out(brake_open));

	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	task automatic give_verdict();
		if (n_errors == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// Both channels offered at once, each dropped at its own take
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		r = 2'h1;
		@(posedge clk_sys_in);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		for (n = 0; n < 100 && r === 2'h1; n++) begin
			@(posedge clk_sys_in);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
			end
		end
		if (n >= 100) begin
			n_errors++;
			give_verdict();
		end
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		r = 2'h1;
		@(posedge clk_sys_in);
		{araddr, arvalid, rready} <= {a, 2'h3};
		for (n = 0; n < 100 && r === 2'h1; n++) begin
			@(posedge clk_sys_in);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				{d, r} = {rdata, rresp};
				rready <= 1'b0;
			end
		end
		if (n >= 100) begin
			n_errors++;
			give_verdict();
		end
	endtask
	// Waits on aux1 (0), motor enable (1) or override (2)
	task automatic wt(input int k, input logic v, input int lim, output int n);
		for (n = 0; n < lim && (k == 0 ? aux1 : k == 1 ? motor_en : ovr) !== v; n++)
			@(posedge clk_sys_in);
		if (n >= lim) begin
			n_errors++;
			give_verdict();
		end
	endtask
	task automatic do_reset();
		resetn_in <= 1'b0;
		repeat (10) @(posedge clk_sys_in);
		chk({motor_en, aux1, awready}, 3'h1);
		resetn_in <= 1'b1;
	endtask

	initial begin
		{resetn_in, awvalid, wvalid, bready, arvalid, rready, want_drive} = 7'h0;
		{want_rev, coil_cut, trap_sw, inhibit, awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		do_reset();
		foreach (ROWS[i]) begin
			if (ROWS[i].we) axw(ROWS[i].a, ROWS[i].d, resp);
			if (ROWS[i].we) chk(resp, ROWS[i].r);
			axr(ROWS[i].a, rd, resp);
			chk({rd, resp}, {ROWS[i].e, ROWS[i].r});
		end
		chk({motion, v36, gain}, {32'h3232320a, 1'b1, 11'h4fb});
		// Single byte lane merges into the stored word
		wstrb <= 4'h2;
		axw(OFS_MOTION, 32'haaaa14aa, resp);
		wstrb <= 4'hf;
		axr(OFS_MOTION, rd, resp);
		chk(rd, 32'h3232140a);
		// Second reset clears the fence lock
		do_reset();
		axr(OFS_FENCE, rd, resp);
		chk(rd, 32'h6400);
		axw(OFS_CTRL, 32'h10, resp);
		axw(OFS_BRAKE, 32'h00010002, resp);
		axw(OFS_MASK, 32'h1, resp);
		chk(chk_en, 1'b1);
		want_drive <= 1'b1;
		wt(1, 1'b1, 20, c);
		chk(aux1, 1'b0);
		wt(0, 1'b1, 60, c);
		chk(c >= TK && c <= 3 * TK + 4, 1'b1);
		repeat (2) @(posedge clk_sys_in);
		chk(irq, 1'b1);
		axr(OFS_STATUS, rd, resp);
		chk(rd[ST_REL], 1'b1);
		repeat (2) @(posedge clk_sys_in);
		chk(irq, 1'b0);
		want_drive <= 1'b0;
		wt(0, 1'b0, 60, c);
		chk(c <= 2 * TK + 4, 1'b1);
		coil_cut <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		axr(OFS_STATUS, rd, resp);
		chk({irq, rd[ST_AOFF], rd[ST_OPEN]}, 3'h3);
		axw(OFS_CTRL, 32'h20, resp);
		axw(OFS_AUXDLY, 32'h0, resp);
		axr(OFS_STATUS, rd, resp);
		chk({chk_en, rd[ST_OPEN]}, 2'h0);
		{want_drive, coil_cut} <= 2'h2;
		wt(0, 1'b1, 30, c);
		want_rev <= 1'b1;
		wt(0, 1'b0, 30, c);
		axw(OFS_CTRL, 32'h30, resp);
		wt(0, 1'b1, 30, c);
		want_rev <= 1'b0;
		wt(0, 1'b0, 30, c);
		axw(OFS_CTRL, 32'h40, resp);
		wt(0, 1'b1, 30, c);
		axw(OFS_AUXDLY, 32'h1, resp);
		want_drive <= 1'b0;
		repeat (150) @(posedge clk_sys_in);
		chk(aux1, 1'b1);
		want_drive <= 1'b1;
		repeat (50) @(posedge clk_sys_in);
		want_drive <= 1'b0;
		repeat (200) @(posedge clk_sys_in);
		chk(aux1, 1'b1);
		wt(0, 1'b0, 100, c);
		want_drive <= 1'b1;
		wt(0, 1'b1, 30, c);
		inhibit <= 1'b1;
		wt(0, 1'b0, 300, c);
		chk(c >= 200, 1'b1);
		{want_drive, inhibit} <= 2'h0;
		axw(OFS_TRAP, 32'h128, resp);
		trap_sw <= 1'b1;
		wt(2, 1'b1, 20, c);
		chk(speed, 7'h28);
		repeat ((TICKS_PER_S - 2) * TK) @(posedge clk_sys_in);
		chk(ovr, 1'b1);
		wt(2, 1'b0, 3 * TK + 4, c);
		chk(speed, 7'h0);
		axr(OFS_STATUS, rd, resp);
		chk(rd[ST_TEXP:ST_TON], 2'h3);
		trap_sw <= 1'b0;
		axw(OFS_CTRL, 32'h140, resp);
		wt(2, 1'b1, 20, c);
		trap_sw <= 1'b1;
		wt(2, 1'b0, 20, c);
		give_verdict();
	end
endmodule // drive_brake_aux_sequencer_bench
